//--- alg_defs.svh
// offsets, field positions, reset values and timing counts of the gain stage
`ifndef ALG_DEFS_SVH
`define ALG_DEFS_SVH

// ==========================================================
// register word addresses
`define ALG_REG_CTRL 4'h0
`define ALG_REG_SCALE 4'h1
`define ALG_REG_STATUS 4'h2
`define ALG_REG_GAIN 4'h3

// ==========================================================
// fields and reset values
`define ALG_CTRL_NORM 0
`define ALG_CTRL_DRC 1
`define ALG_CTRL_MIX 2
`define ALG_CTRL_TGT 12:8
`define ALG_CTRL_MASK 32'h0000_1F07
`define ALG_CTRL_RST 32'h0000_1F07
`define ALG_SC_CUT 7:0
`define ALG_SC_BOOST 15:8
`define ALG_SCALE_MASK 32'h0000_FFFF
`define ALG_SCALE_RST 32'h0000_8080
`define ALG_ST_BLKERR 21
`define ALG_ST_STALE 22

// ==========================================================
// arithmetic constants, gains in quarter decibels
`define ALG_DN_RESERVED 5'h00
`define ALG_DN_FALLBACK 5'h1F
`define ALG_DRC_POS 8'h60
`define ALG_DRC_NEG 8'hA0
`define ALG_UNITY_SCALE 8'h80
`define ALG_SCALE_SHIFT 7
`define ALG_Q_MIN 12'hE98
`define ALG_Q_MAX 12'h0A8
`define ALG_Q_BIAS 11'h180
`define ALG_Q_PER_OCT 10'h018
`define ALG_EXPO_BIAS 5'h10
`define ALG_MANT_FRAC 14
`define ALG_MANT_ONE 16'h4000
`define ALG_BLOCKS_PER_FRAME 3'h6

// ==========================================================
// timing
`define ALG_CLK_HZ 20000000
`define ALG_FRAME_MS 32
`define ALG_FRAME_CYCLES (`ALG_CLK_HZ / 1000 * `ALG_FRAME_MS)
`define ALG_FRAME_MISS 2

`endif

//--- alg_pkg.sv
// types shared by the gain stage modules
package alg_pkg;
   typedef logic signed [10:0] alg_qdb_type;
   typedef logic signed [15:0] alg_pcm_type;
   typedef enum logic [2:0] {
      ALG_SVC_COMPLETE_MAIN = 3'h0,
      ALG_SVC_MUSIC_FX = 3'h1,
      ALG_SVC_NARRATIVE = 3'h2,
      ALG_SVC_HEARING = 3'h3,
      ALG_SVC_DIALOGUE = 3'h4,
      ALG_SVC_COMMENTARY = 3'h5,
      ALG_SVC_EMERGENCY = 3'h6,
      ALG_SVC_VOICE_OVER = 3'h7
   } alg_svc_type;
   typedef enum logic [1:0] {
      ALG_BUS_IDLE = 2'b01,
      ALG_BUS_ACK = 2'b10
   } alg_bus_state_type;
endpackage : alg_pkg

//--- alg_gain_if.sv
// gain word in quarter decibels and its linear mantissa and exponent
`timescale 1ns/1ps
`default_nettype none
interface alg_gain_if;
   alg_pkg::alg_qdb_type q;
   logic [15:0] mant;
   logic signed [4:0] expo;
   modport conv (input q, output mant, output expo);
   modport user (input mant, input expo);
endinterface : alg_gain_if
`default_nettype wire

//--- alg_db2lin.sv
// quarter-decibel gain to linear mantissa and power-of-two exponent
`timescale 1ns/1ps
`default_nettype none
`include "alg_defs.svh"
module alg_db2lin (
   alg_gain_if.conv gi // gain in, linear factor out
);
   import alg_pkg::*;
   // ==========================================================
   // 24 quarter-dB steps per octave, so 6 dB is taken as exactly 2x
   logic [15:0] lut [0:23];
   logic [9:0] qo;
   logic [4:0] oct;
   logic [4:0] rem;

   assign lut = '{16'h4000, 16'h41E0, 16'h43CE, 16'h45CB, 16'h47D6,
                  16'h49F1, 16'h4C1C, 16'h4E57, 16'h50A3, 16'h52FF,
                  16'h556E, 16'h57EF, 16'h5A82, 16'h5D2A, 16'h5FE4,
                  16'h62B4, 16'h6598, 16'h6892, 16'h6BA2, 16'h6ECA,
                  16'h7209, 16'h7560, 16'h78D1, 16'h7C5B};
   // bias keeps the division unsigned; caller clamps q to the bias range
   assign qo = 10'(gi.q + $signed(`ALG_Q_BIAS));
   assign oct = 5'(qo / `ALG_Q_PER_OCT);
   assign rem = 5'(qo % `ALG_Q_PER_OCT);
   assign gi.expo = $signed(5'(oct - `ALG_EXPO_BIAS));
   assign gi.mant = lut[rem];
endmodule : alg_db2lin
`default_nettype wire

//--- alg_pcm_scale.sv
// one pcm sample times a linear gain, saturated, one register stage
`timescale 1ns/1ps
`default_nettype none
`include "alg_defs.svh"
module alg_pcm_scale (
   input wire logic core_clk_i, // system clock
   input wire logic reset_i, // sync reset, high
   input wire logic ce_i, // clock enable
   input wire logic in_valid_i, // sample strobe
   input wire alg_pkg::alg_pcm_type pcm_i, // sample in
   alg_gain_if.user gi, // linear gain
   output logic out_valid_o, // registered strobe
   output alg_pkg::alg_pcm_type pcm_o // registered sample
);
   import alg_pkg::*;
   logic signed [32:0] prod;
   logic signed [47:0] wide;
   logic signed [47:0] shifted;
   logic signed [47:0] q14;
   logic ovf;
   alg_pcm_type sat;

   assign prod = $signed({{17{pcm_i[15]}}, pcm_i})
               * $signed({17'h0_0000, gi.mant});
   assign wide = {{15{prod[32]}}, prod};
   assign shifted = gi.expo[4] ? (wide >>> 5'(-gi.expo))
                               : (wide <<< gi.expo);
   assign q14 = shifted >>> `ALG_MANT_FRAC;
   // clip rather than wrap, wrap is audible as a loud click
   assign ovf = !((&q14[47:15]) || !(|q14[47:15]));
   assign sat = ovf ? (q14[47] ? 16'sh8000 : 16'sh7FFF) : q14[15:0];

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         out_valid_o <= 1'b0;
         pcm_o <= 16'sh0000;
      end else if (ce_i) begin
         out_valid_o <= in_valid_i;
         pcm_o <= sat;
      end
   end

   chk_unity_pass: assert property (@(posedge core_clk_i)
      disable iff (reset_i)
      ce_i && in_valid_i && gi.mant == `ALG_MANT_ONE && gi.expo == 0
      |=> pcm_o == $past(pcm_i))
      else $error("unity gain altered a sample");
endmodule : alg_pcm_scale
`default_nettype wire

//--- alg_gain_stage.sv
// loudness normalisation and dynamic range gain stage, top level
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "alg_defs.svh"
module alg_gain_stage #(
   parameter int FRAME_CYCLES = `ALG_FRAME_CYCLES // frame period
) (
   input wire logic core_clk_i, // 20 MHz clock
   input wire logic reset_i, // sync reset, high
   input wire logic ce_i, // clock enable
   input wire logic hdr_valid_i, // header fields strobe
   input wire logic hdr_assoc_i, // header is associated stream
   input wire logic [4:0] hdr_dialnorm_i, // dialogue level field
   input wire logic [2:0] hdr_svc_i, // service type field
   input wire logic hdr_mono_i, // stream is single channel
   input wire logic blk_valid_i, // block gain strobe
   input wire logic blk_assoc_i, // gain is associated stream's
   input wire logic [7:0] blk_gain_i, // signed quarter dB
   input wire logic pcm_valid_i, // sample pair strobe
   input wire alg_pkg::alg_pcm_type pcm_main_i, // main sample
   input wire alg_pkg::alg_pcm_type pcm_assoc_i, // associated sample
   output logic pcm_valid_o, // output sample strobe
   output alg_pkg::alg_pcm_type pcm_o, // scaled mixed sample
   input wire logic [3:0] avs_address_i, // word address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // byte lanes
   output logic [31:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o // stall
);
   import alg_pkg::*;

   // ==========================================================
   // functions
   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be,
      input logic [31:0] mask);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      return (old & ~m) | (nw & m);
   endfunction : be_merge

   function automatic alg_qdb_type norm_gain(input logic [4:0] dn,
      input logic [4:0] tgt);
      logic signed [5:0] d;
      d = $signed({1'b0, dn}) - $signed({1'b0, tgt});
      return {{3{d[5]}}, d, 2'b00};
   endfunction : norm_gain

   function automatic alg_qdb_type scale_drc(input logic signed [7:0] w,
      input logic [7:0] cut, input logic [7:0] boost);
      logic signed [7:0] c;
      logic [7:0] s;
      logic signed [17:0] p;
      c = (w > $signed(`ALG_DRC_POS)) ? $signed(`ALG_DRC_POS) :
          (w < $signed(`ALG_DRC_NEG)) ? $signed(`ALG_DRC_NEG) : w;
      s = w[7] ? cut : boost;
      if (s > `ALG_UNITY_SCALE) s = `ALG_UNITY_SCALE;
      // zero factor gives a flat block
      p = $signed({{10{c[7]}}, c}) * $signed({10'h000, s});
      return alg_qdb_type'(p >>> `ALG_SCALE_SHIFT);
   endfunction : scale_drc

   function automatic alg_qdb_type clamp_q(input alg_qdb_type n,
      input alg_qdb_type d);
      logic signed [11:0] s;
      s = {n[10], n} + {d[10], d};
      if (s < $signed(`ALG_Q_MIN)) s = $signed(`ALG_Q_MIN);
      if (s > $signed(`ALG_Q_MAX)) s = $signed(`ALG_Q_MAX);
      return alg_qdb_type'(s);
   endfunction : clamp_q

   // ==========================================================
   // register bus
   alg_bus_state_type state_q;
   alg_bus_state_type state_d;
   logic [31:0] ctrl_q;
   logic [31:0] scale_q;
   logic [31:0] rd_word;
   logic [31:0] status_word;
   logic [31:0] gain_word;
   logic bus_req;
   logic bus_ack;
   logic wr_fire;
   logic rd_take;
   logic sel_ctrl;
   logic sel_scale;
   logic sel_status;
   logic sel_gain;

   assign bus_req = avs_read_i | avs_write_i;
   assign bus_ack = (state_q == ALG_BUS_ACK) && ce_i;
   assign avs_waitrequest_o = bus_req && !bus_ack;
   assign wr_fire = avs_write_i && bus_ack;
   assign rd_take = ce_i && avs_read_i && (state_q == ALG_BUS_IDLE);
   assign state_d = (state_q == ALG_BUS_IDLE && bus_req) ? ALG_BUS_ACK
                                                         : ALG_BUS_IDLE;
   assign sel_ctrl = avs_address_i == `ALG_REG_CTRL;
   assign sel_scale = avs_address_i == `ALG_REG_SCALE;
   assign sel_status = avs_address_i == `ALG_REG_STATUS;
   assign sel_gain = avs_address_i == `ALG_REG_GAIN;
   assign rd_word = sel_ctrl ? ctrl_q :
                    sel_scale ? scale_q :
                    sel_status ? status_word :
                    sel_gain ? gain_word : 32'h0000_0000;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_q <= ALG_BUS_IDLE;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (rd_take) begin
         avs_readdata_o <= rd_word;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ctrl_q <= `ALG_CTRL_RST;
         scale_q <= `ALG_SCALE_RST;
      end else if (wr_fire && sel_ctrl) begin
         ctrl_q <= be_merge(ctrl_q, avs_writedata_i, avs_byteenable_i,
                            `ALG_CTRL_MASK);
      end else if (wr_fire && sel_scale) begin
         scale_q <= be_merge(scale_q, avs_writedata_i, avs_byteenable_i,
                             `ALG_SCALE_MASK);
      end
   end

   // ==========================================================
   // stream header and block gain capture
   logic [4:0] dn_in;
   logic [4:0] dn_main_q;
   logic [4:0] dn_assoc_q;
   alg_svc_type svc_q;
   logic mono_q;
   logic assoc_seen_q;
   logic signed [7:0] drc_main_q;
   logic signed [7:0] drc_assoc_q;
   logic hdr_main;
   logic hdr_assoc;

   // dialogue level field
   // reserved code 0 falls back to the quietest setting
   assign dn_in = (hdr_dialnorm_i == `ALG_DN_RESERVED) ? `ALG_DN_FALLBACK
                                                      : hdr_dialnorm_i;
   assign hdr_main = ce_i && hdr_valid_i && !hdr_assoc_i;
   assign hdr_assoc = ce_i && hdr_valid_i && hdr_assoc_i;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         dn_main_q <= `ALG_DN_FALLBACK;
      end else if (hdr_main) begin
         dn_main_q <= dn_in;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         dn_assoc_q <= `ALG_DN_FALLBACK;
         svc_q <= ALG_SVC_COMPLETE_MAIN;
         mono_q <= 1'b0;
         assoc_seen_q <= 1'b0;
      end else if (hdr_assoc) begin
         dn_assoc_q <= dn_in;
         svc_q <= alg_svc_type'(hdr_svc_i);
         mono_q <= hdr_mono_i;
         assoc_seen_q <= 1'b1;
      end
   end

   // words may be rewritten upstream; audio path is independent
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         drc_main_q <= 8'sh00;
         drc_assoc_q <= 8'sh00;
      end else if (ce_i && blk_valid_i) begin
         if (blk_assoc_i) begin
            drc_assoc_q <= $signed(blk_gain_i);
         end else begin
            drc_main_q <= $signed(blk_gain_i);
         end
      end
   end

   // ==========================================================
   // frame bookkeeping: block count and missing-frame watchdog
   logic [2:0] blk_cnt_q;
   logic frame_seen_q;
   logic blk_err_q;
   logic stale_q;
   logic [21:0] wd_q;
   logic wd_hit;
   logic clr_err;
   logic clr_stale;
   logic set_err;

   assign wd_hit = wd_q == 22'(FRAME_CYCLES * `ALG_FRAME_MISS - 1);
   assign clr_err = wr_fire && sel_status && avs_byteenable_i[2]
                    && avs_writedata_i[`ALG_ST_BLKERR];
   assign clr_stale = wr_fire && sel_status && avs_byteenable_i[2]
                      && avs_writedata_i[`ALG_ST_STALE];
   assign set_err = hdr_main && frame_seen_q
                    && blk_cnt_q != `ALG_BLOCKS_PER_FRAME;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         blk_cnt_q <= 3'h0;
         frame_seen_q <= 1'b0;
      end else if (hdr_main) begin
         blk_cnt_q <= 3'h0;
         frame_seen_q <= 1'b1;
      end else if (ce_i && blk_valid_i && !blk_assoc_i
                   && blk_cnt_q != 3'h7) begin
         blk_cnt_q <= blk_cnt_q + 3'h1;
      end
   end

   // frame watchdog; set wins over clear
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wd_q <= 22'h00_0000;
         blk_err_q <= 1'b0;
         stale_q <= 1'b0;
      end else if (ce_i) begin
         wd_q <= (hdr_main || !frame_seen_q || wd_hit) ? 22'h00_0000
                                                       : wd_q + 22'h00_0001;
         blk_err_q <= set_err || (blk_err_q && !clr_err);
         stale_q <= (wd_hit && !hdr_main) || (stale_q && !clr_stale);
      end
   end

   // ==========================================================
   // gain routing and decibel arithmetic
   logic steer;
   logic signed [7:0] drc_m_eff;
   logic signed [7:0] drc_a_eff;
   alg_qdb_type norm_main;
   alg_qdb_type norm_assoc;
   alg_qdb_type drc_m_sc;
   alg_qdb_type drc_a_sc;
   alg_qdb_type q_main;
   alg_qdb_type q_assoc;

   // single-channel narration or commentary, or voice-over
   assign steer = assoc_seen_q && (svc_q == ALG_SVC_VOICE_OVER
                  || (mono_q && (svc_q == ALG_SVC_NARRATIVE
                  || svc_q == ALG_SVC_COMMENTARY)));
   // own words otherwise; steered words leave the voice itself flat
   assign drc_m_eff = steer ? drc_assoc_q : drc_main_q;
   assign drc_a_eff = steer ? 8'sh00 : drc_assoc_q;
   // level below full scale, so gain is level minus target
   // level minus target evens out dialogue
   assign norm_main = ctrl_q[`ALG_CTRL_NORM]
                      ? norm_gain(dn_main_q, ctrl_q[`ALG_CTRL_TGT]) : '0;
   // associated stream uses its own level
   assign norm_assoc = ctrl_q[`ALG_CTRL_NORM]
                      ? norm_gain(dn_assoc_q, ctrl_q[`ALG_CTRL_TGT]) : '0;
   // cut and boost factors picked by sign
   assign drc_m_sc = ctrl_q[`ALG_CTRL_DRC] ? scale_drc(drc_m_eff,
                     scale_q[`ALG_SC_CUT], scale_q[`ALG_SC_BOOST]) : '0;
   assign drc_a_sc = ctrl_q[`ALG_CTRL_DRC] ? scale_drc(drc_a_eff,
                     scale_q[`ALG_SC_CUT], scale_q[`ALG_SC_BOOST]) : '0;
   assign q_main = clamp_q(norm_main, drc_m_sc);
   assign q_assoc = clamp_q(norm_assoc, drc_a_sc);

   assign status_word = {9'h000, stale_q, blk_err_q, steer, 1'b0, svc_q,
                         3'h0, dn_assoc_q, 3'h0, dn_main_q};
   assign gain_word = {5'h00, q_assoc, 5'h00, q_main};

   // ==========================================================
   // per-stream scaling and mix
   alg_pcm_type sc_pcm [2];
   logic [1:0] sc_valid;
   logic signed [16:0] mix_sum;
   logic mix_on;

   for (genvar i = 0; i < 2; i++) begin : g_path
      alg_gain_if gif ();
      assign gif.q = (i == 0) ? q_main : q_assoc;
      alg_db2lin u_conv (
         .gi(gif.conv)
      );
      alg_pcm_scale u_scale (
         .core_clk_i(core_clk_i),
         .reset_i(reset_i),
         .ce_i(ce_i),
         .in_valid_i(pcm_valid_i),
         .pcm_i((i == 0) ? pcm_main_i : pcm_assoc_i),
         .gi(gif.user),
         .out_valid_o(sc_valid[i]),
         .pcm_o(sc_pcm[i])
      );
   end

   // mix after each stream is scaled
   assign mix_on = ctrl_q[`ALG_CTRL_MIX] && assoc_seen_q;
   assign mix_sum = {sc_pcm[0][15], sc_pcm[0]}
                  + (mix_on ? {sc_pcm[1][15], sc_pcm[1]} : 17'h0_0000);

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pcm_valid_o <= 1'b0;
         pcm_o <= 16'sh0000;
      end else if (ce_i) begin
         pcm_valid_o <= sc_valid[0];
         pcm_o <= (mix_sum[16] == mix_sum[15]) ? mix_sum[15:0] :
                  (mix_sum[16] ? 16'sh8000 : 16'sh7FFF);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   chk_level_capture: assert property (
      hdr_main && hdr_dialnorm_i != 5'h00
      |=> dn_main_q == $past(hdr_dialnorm_i))
      else $error("dialogue level not captured");
   chk_uniform_level: assert property (
      ctrl_q[`ALG_CTRL_NORM]
      && dn_main_q == ctrl_q[`ALG_CTRL_TGT] |-> q_main == drc_m_sc)
      else $error("dialogue at target not unity");
   chk_target_step: assert property (
      ctrl_q[`ALG_CTRL_NORM]
      && dn_main_q == ctrl_q[`ALG_CTRL_TGT] + 5'h01
      |-> q_main == drc_m_sc + 11'sh004)
      else $error("one dB level step not four quarter steps");
   chk_block_apply: assert property (
      ce_i && blk_valid_i && !blk_assoc_i
      |=> drc_main_q == $past(blk_gain_i))
      else $error("block gain word not taken");
   chk_gain_range: assert property (
      drc_m_sc <= 96 && drc_m_sc >= -96)
      else $error("block gain beyond 24 dB");
   chk_cut_sign: assert property (
      drc_m_eff[7] |-> drc_m_sc <= 0)
      else $error("attenuation word produced boost");
   chk_default_pass: assert property (
      $rose(ctrl_q[`ALG_CTRL_DRC]) || (ctrl_q[`ALG_CTRL_DRC]
      && scale_q[15:0] == 16'h8080 && drc_m_eff == 8'sh10)
      |-> !ctrl_q[`ALG_CTRL_DRC] || drc_m_sc == 16
      || drc_m_eff != 8'sh10 || scale_q[15:0] != 16'h8080)
      else $error("default scale altered gain word");
   chk_zero_factor: assert property (
      ctrl_q[`ALG_CTRL_DRC] && scale_q[`ALG_SC_BOOST] == 8'h00
      && !drc_m_eff[7] |-> drc_m_sc == 0)
      else $error("zero factor left compression on");
   chk_route_steer: assert property (
      steer && !hdr_assoc && ce_i && blk_valid_i && blk_assoc_i
      |=> drc_m_eff == $past(blk_gain_i))
      else $error("voice-over gain not steering main");
   chk_route_own: assert property (
      !assoc_seen_q |-> drc_m_eff == drc_main_q && drc_a_eff == drc_assoc_q)
      else $error("gain word crossed streams");
   chk_block_count: assert property (
      set_err |=> blk_err_q ##1 (blk_err_q || $past(clr_err)))
      else $error("short frame not flagged");
   chk_mix_latency: assert property (
      ce_i && pcm_valid_i ##1 ce_i |=> pcm_valid_o)
      else $error("sample lost in gain path");

   cov_steered: cover property (steer && pcm_valid_o);
   cov_mixed: cover property (mix_on && pcm_valid_o);
   cov_short_frame: cover property (set_err);
   cov_bus_write: cover property (wr_fire && sel_scale);
endmodule : alg_gain_stage
`default_nettype wire

//--- alg_src_model.sv
// upstream parser model: header, block gain and sample strobes
`timescale 1ns/1ps
`default_nettype none
module alg_src_model (
   input wire logic clk_i, // system clock
   output logic hv_o, // header strobe
   output logic ha_o, // header is associated
   output logic [4:0] hdn_o, // dialogue level
   output logic [2:0] hsvc_o, // service type
   output logic hmono_o, // single channel
   output logic bv_o, // gain word strobe
   output logic ba_o, // gain word is associated
   output logic [7:0] bg_o, // gain word
   output logic pv_o, // sample strobe
   output logic [15:0] pm_o, // main sample
   output logic [15:0] pa_o // associated sample
);
   initial begin
      {hv_o, ha_o, hdn_o, hsvc_o, hmono_o} = '0;
      {bv_o, ba_o, bg_o, pv_o, pm_o, pa_o} = '0;
   end
   task automatic hdr(input logic a, input logic [4:0] dn,
      input logic [2:0] s, input logic m);
      @(posedge clk_i);
      hv_o <= 1'b1; ha_o <= a; hdn_o <= dn; hsvc_o <= s; hmono_o <= m;
      @(posedge clk_i);
      hv_o <= 1'b0;
      hdn_o <= ~dn;
   endtask : hdr
   task automatic blk(input logic a, input logic [7:0] g);
      @(posedge clk_i);
      bv_o <= 1'b1; ba_o <= a; bg_o <= g;
      @(posedge clk_i);
      bv_o <= 1'b0;
      bg_o <= ~g;
   endtask : blk
   // released lines show the inverse, not a stale value
   task automatic pcm(input logic [15:0] m, input logic [15:0] s);
      @(posedge clk_i);
      pv_o <= 1'b1; pm_o <= m; pa_o <= s;
      @(posedge clk_i);
      pv_o <= 1'b0;
      pm_o <= ~m;
      pa_o <= ~s;
   endtask : pcm
endmodule : alg_src_model
`default_nettype wire

//--- audio_loudness_gain_stage_test.sv
// self-checking bench of the gain stage
`timescale 1ns/1ps
`default_nettype none
`include "alg_defs.svh"
module audio_loudness_gain_stage_test;
   logic clk = 0, rst = 1, rd = 0, wr = 0, wreq, pv, hv, ha, hm, bv, ba, psv;
   logic [3:0] adr = '0;
   logic [31:0] wd = '0, rdat, q;
   logic [4:0] hdn;
   logic [2:0] hs;
   logic [7:0] bg;
   logic [15:0] pm, pa, po;
   int error_cnt = 0, checks_done = 0;
   always #25 clk = ~clk;
   alg_src_model src (.clk_i(clk), .hv_o(hv), .ha_o(ha), .hdn_o(hdn),
      .hsvc_o(hs), .hmono_o(hm), .bv_o(bv), .ba_o(ba), .bg_o(bg),
      .pv_o(psv), .pm_o(pm), .pa_o(pa));
   alg_gain_stage #(.FRAME_CYCLES(50)) u_dut (.core_clk_i(clk),
      .reset_i(rst), .ce_i(1'b1), .hdr_valid_i(hv), .hdr_assoc_i(ha),
      .hdr_dialnorm_i(hdn), .hdr_svc_i(hs), .hdr_mono_i(hm),
      .blk_valid_i(bv), .blk_assoc_i(ba), .blk_gain_i(bg),
      .pcm_valid_i(psv), .pcm_main_i(pm), .pcm_assoc_i(pa),
      .pcm_valid_o(pv), .pcm_o(po), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq));
   task automatic cmp(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (e !== g) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic av(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      // no cycle limit here: a hung slave is ended by the watchdog
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : av
   task automatic rgain(input logic [10:0] e);
      av(0, `ALG_REG_GAIN, 0);
      cmp("main gain", {21'h0, e}, {21'h0, q[10:0]});
   endtask : rgain
   task automatic t_regs;
      av(0, `ALG_REG_CTRL, 0); cmp("ctrl", `ALG_CTRL_RST, q);
      av(0, `ALG_REG_SCALE, 0); cmp("scale", `ALG_SCALE_RST, q);
      av(0, 4'h9, 0); cmp("unmapped", 32'h0, q);
      av(1, `ALG_REG_SCALE, 32'hFFFF_1234);
      av(0, `ALG_REG_SCALE, 0); cmp("scale rw", 32'h0000_1234, q);
      av(1, `ALG_REG_SCALE, `ALG_SCALE_RST);
      $display("test regs done");
   endtask : t_regs
   task automatic t_norm;
      src.hdr(0, 5'd20, 3'h0, 0);
      av(0, `ALG_REG_STATUS, 0);
      cmp("level", 32'd20, {27'h0, q[4:0]});
      rgain(11'h7D4);
      src.blk(0, 8'h10);
      rgain(11'h7E4);
      av(1, `ALG_REG_CTRL, 32'h0000_1307);
      rgain(11'h014);
      av(1, `ALG_REG_CTRL, `ALG_CTRL_RST);
      $display("test norm done");
   endtask : t_norm
   task automatic t_drc;
      src.hdr(0, 5'd31, 3'h0, 0);
      av(0, `ALG_REG_STATUS, 0);
      cmp("block error", 32'h0000_0001, {31'h0, q[21]});
      src.blk(0, 8'h7F);
      rgain(11'h060);
      src.blk(0, 8'hF0);
      rgain(11'h7F0);
      av(1, `ALG_REG_SCALE, 32'h0000_0040);
      rgain(11'h7F8);
      src.blk(0, 8'h10);
      rgain(11'h000);
      av(1, `ALG_REG_SCALE, 32'h0000_0000);
      src.blk(0, 8'hF0);
      rgain(11'h000);
      av(1, `ALG_REG_SCALE, `ALG_SCALE_RST);
      $display("test drc done");
   endtask : t_drc
   task automatic t_steer;
      for (int s = 0; s < 8; s++) begin
         src.hdr(1, 5'd31, s[2:0], 1);
         av(0, `ALG_REG_STATUS, 0);
         cmp("steer", {31'h0, s == 2 || s == 5 || s == 7},
             {31'h0, q[20]});
      end
      src.blk(0, 8'h00);
      src.blk(1, 8'h08);
      rgain(11'h008);
      src.blk(1, 8'h00);
      $display("test steer done");
   endtask : t_steer
   task automatic t_pcm;
      int n;
      n = 0;
      // voice-over still steers: its 6 dB word doubles the main sample
      src.blk(1, 8'h18);
      src.pcm(16'h0100, 16'h0010);
      while (pv !== 1'b1 && n < 8) begin
         @(posedge clk);
         n++;
      end
      cmp("pcm strobe", 32'h0000_0001, {31'h0, pv});
      cmp("pcm", 32'h0000_0210, {16'h0, po});
      $display("test pcm done");
   endtask : t_pcm
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_norm;
      t_drc;
      t_steer;
      t_pcm;
      report_and_stop;
   end
   // bench needs well under 1000 cycles
   initial begin
      #500us;
      error_cnt++;
      report_and_stop;
   end
endmodule : audio_loudness_gain_stage_test
`default_nettype wire
